// file: design/card_reader_cfg.svh
// Constants of the card reader command interpreter
`ifndef CARD_READER_CFG_SVH
`define CARD_READER_CFG_SVH
// Framing characters
`define CH_STX 8'h02
`define CH_ETX 8'h03
`define CH_ACK 8'h06
`define CH_NAK 8'h15
// Command classes and functions
`define CLS_VER 8'h10
`define CLS_PARAM 8'h12
`define CLS_CAL 8'h13
`define CLS_OTP 8'h15
`define CLS_STAT 8'h16
`define CLS_RETRY 8'h17
`define CLS_SWRST 8'h18
`define FN_STD 8'h31
`define FN_OTP 8'h33
// Expected command data lengths and response lengths
`define LEN_PARAM 8'h04
`define LEN_CAL 8'h05
`define LEN_VER_RSP 8'h10
`define LEN_STAT_RSP 8'h06
`define LEN_ONE 8'h01
// Error codes
`define ERR_STXETX 8'h61
`define ERR_UNKNOWN 8'h62
`define ERR_BCC 8'h63
`define ERR_LEN 8'h64
`define ERR_NODATA 8'h65
`define ERR_OTP_FULL 8'h71
`define ERR_OTP_EMPTY 8'h72
// Card read error codes, produced upstream and passed through
`define ERR_PREAMBLE 8'h51
`define ERR_POSTAMBLE 8'h52
`define ERR_LRC 8'h53
`define ERR_PARITY 8'h54
`define ERR_BLANK 8'h55
// Track identifiers and frame mode base
`define TRK1_ID 8'h25
`define TRK2_ID 8'h3F
`define TRK3_ID 8'h5E
`define MODE_BASE 8'h31
// Reset values of user settings and OTP write limit
`define RST_TX_MODE 8'h02
`define RST_ALL_ERR 8'h00
`define OTP_MAX 3'h4
// Timing: clock, software reset time, baud window
`define CLK_HZ 40000000
`define SWRST_MS 50
`define SWRST_CYC ((`CLK_HZ / 1000) * `SWRST_MS)
`define BAUD_LO_BPS 9600
`define BAUD_HI_BPS 19200
`define PER_MAX (`CLK_HZ / `BAUD_LO_BPS)
`define PER_MIN ((`CLK_HZ + `BAUD_HI_BPS - 1) / `BAUD_HI_BPS)
`define CAL_SHIFT 5
`endif

// file: design/card_reader_pkg.sv
// Types shared by the card reader command interpreter
package card_reader_pkg;
  // Longest track payload kept per track
  localparam int TRK_MAX = 8;
  // One byte with its valid flag
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_t;
  // One recovered track: good flag, error code, length, payload
  typedef struct packed {
    logic ok;
    logic [7:0] code;
    logic [7:0] len;
    logic [TRK_MAX*8-1:0] data;
  } track_t;
  // A card read result of three tracks, with its strobe
  typedef struct packed {
    logic valid;
    track_t [2:0] trk;
  } card_t;
endpackage

// file: design/card_reader_cmd.sv
// Command interpreter and data frame builder of a three-track card reader
// Functional notes
// - Version query answers ACK, length 0x10, text
// - Parameter load stores the first and third of four bytes, echoes them with the others zero
// - Calibration answers one-byte ACK with value
// - OTP write stores calibration, four times max
// - Status returns six bytes ending with calibration
// - Retry resends last frame or NAK
// - Software reset silent, done within 50 ms
// - Software reset restores defaults, reloads OTP
// - Software reset fails on frame, check byte, unknown or length error
// - Card read error codes 0x51 to 0x55
// - Command reception error codes 0x61 to 0x65
// - OTP error codes 0x71 and 0x72
// - Mode 0x02 sends raw binary bytes
// - Baud tuned from calibration bit period
// - Frame carries three tracks with ID blocks
// - Mode byte is 0x31 plus mode
// - STX/ETX framing with XOR check byte
// - Status byte ACK 0x06 or NAK 0x15
// - Response echoes class and function, data length
// - Serial characters are 8N1, LSB first
`timescale 1ns/10ps
`include "card_reader_cfg.svh"
module card_reader_cmd #(
  parameter int SWRST_CYCLES = `SWRST_CYC,
  parameter logic [127:0] VER_TEXT = 128'h4341_5244_2D52_4452_2056_4552_3A30_2E30 // Arbitrary text
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire card_reader_pkg::byte_t rx_in,
  output logic rx_ready,
  input wire logic [15:0] rx_bit_period,
  output card_reader_pkg::byte_t tx_out,
  input wire logic tx_ready,
  input wire card_reader_pkg::card_t card_in,
  output logic card_ready,
  output logic [15:0] baud_period,
  output logic otp_wr,
  output logic [7:0] otp_wdata,
  output logic busy
);
  import card_reader_pkg::*;
  localparam int BUF_N = 3 + 3 * (3 + TRK_MAX);
  localparam logic [31:0] SWRST_LOAD = SWRST_CYCLES;

  // Parser states
  typedef enum logic [2:0] {P_STX, P_CLS, P_FN, P_LEN, P_DAT, P_ETX, P_BCC} pstate_t;
  // Transmitter states
  typedef enum logic [0:0] {T_IDLE, T_SEND} tstate_t;

  // Known command check
  function automatic logic known_cmd(input logic [7:0] c, input logic [7:0] f);
    known_cmd = (f == `FN_STD && (c == `CLS_VER || c == `CLS_PARAM || c == `CLS_CAL ||
                 c == `CLS_STAT || c == `CLS_RETRY || c == `CLS_SWRST)) ||
                (c == `CLS_OTP && f == `FN_OTP);
  endfunction

  // Expected command data length per class
  function automatic logic [7:0] exp_len(input logic [7:0] c);
    exp_len = (c == `CLS_PARAM) ? `LEN_PARAM : (c == `CLS_CAL) ? `LEN_CAL : 8'h00;
  endfunction

  // Track identifier by index
  function automatic logic [7:0] trk_id(input int t);
    trk_id = (t == 0) ? `TRK1_ID : (t == 1) ? `TRK2_ID : `TRK3_ID;
  endfunction

  // Parser and settings state
  pstate_t pst_ff, nxt_pst;
  logic [7:0] cls_ff, nxt_cls;       // Received class
  logic [7:0] fn_ff, nxt_fn;         // Received function
  logic [7:0] clen_ff, nxt_clen;     // Received length
  logic [7:0] cnt_ff, nxt_cnt;       // Data byte count
  logic [7:0] dat_ff [5];            // First data bytes
  logic [7:0] nxt_dat [5];
  logic [7:0] bcc_ff, nxt_bcc;       // Running check byte
  logic etxok_ff, nxt_etxok;         // End character seen
  logic [15:0] meas_ff, nxt_meas;    // Measured bit period
  logic [7:0] mode_ff, nxt_mode;     // Transmit mode
  logic [7:0] ate_ff, nxt_ate;       // All-track-error setting
  logic [7:0] cal_ff, nxt_cal;       // Calibration value
  logic cald_ff, nxt_cald;           // Calibration present
  logic [15:0] baud_ff, nxt_baud;    // Tuned bit period
  logic [2:0] otpn_ff, nxt_otpn;     // OTP writes used
  logic [7:0] otpv_ff, nxt_otpv;     // OTP stored value
  logic otpw_ff, nxt_otpw;           // OTP write pulse
  logic [31:0] rcnt_ff, nxt_rcnt;    // Software reset countdown
  logic have_ff, nxt_have;           // Last frame kept
  track_t [2:0] last_ff, nxt_last;   // Last card frame tracks
  logic [7:0] lmode_ff, nxt_lmode;   // Last frame mode byte

  // Decoder outputs toward the transmitter
  logic go_rsp, rsp_ack, go_frm, rst_go, exec, card_take;
  logic [7:0] rsp_n;
  logic [7:0] rsp_d [16];
  logic [7:0] err;
  logic [15:0] per;

  // Transmitter state
  tstate_t tst_ff, nxt_tst;
  logic [7:0] buf_ff [BUF_N];        // Frame bytes STX through ETX
  logic [7:0] nxt_buf [BUF_N];
  logic [5:0] n_ff, nxt_n;           // Bytes in buffer
  logic [5:0] idx_ff, nxt_idx;       // Next byte to send
  logic [7:0] tbcc_ff, nxt_tbcc;     // Outgoing check byte
  byte_t out_ff, nxt_out;            // Byte on offer

  // Handshakes: reception stalls while answering or resetting
  assign rx_ready = (tst_ff == T_IDLE) && (rcnt_ff == 32'h0000_0000);
  assign exec = rx_in.valid && rx_ready && (pst_ff == P_BCC);
  assign card_ready = rx_ready && !exec;
  assign card_take = card_in.valid && card_ready;
  assign tx_out = out_ff;
  assign baud_period = baud_ff;
  assign otp_wr = otpw_ff;
  assign otp_wdata = otpv_ff;
  assign busy = !rx_ready;

  // Clamp of the measured period into the supported baud window
  assign per = (meas_ff > 16'(`PER_MAX)) ? 16'(`PER_MAX) :
               (meas_ff < 16'(`PER_MIN)) ? 16'(`PER_MIN) : meas_ff;

  // Parser, command execution and settings
  always_comb
  begin
    nxt_pst = pst_ff; nxt_cls = cls_ff; nxt_fn = fn_ff; nxt_clen = clen_ff;
    nxt_cnt = cnt_ff; nxt_dat = dat_ff; nxt_bcc = bcc_ff; nxt_etxok = etxok_ff;
    nxt_meas = meas_ff; nxt_mode = mode_ff; nxt_ate = ate_ff; nxt_cal = cal_ff;
    nxt_cald = cald_ff; nxt_baud = baud_ff; nxt_otpn = otpn_ff; nxt_otpv = otpv_ff;
    nxt_otpw = 1'b0; nxt_have = have_ff; nxt_last = last_ff; nxt_lmode = lmode_ff;
    nxt_rcnt = rcnt_ff;
    go_rsp = 1'b0; rsp_ack = 1'b1; rsp_n = 8'h00; go_frm = 1'b0; rst_go = 1'b0; err = 8'h00;
    for (int i = 0; i < 16; i++) rsp_d[i] = 8'h00;
    // Reset countdown
    if (rcnt_ff != 32'h0000_0000)
      nxt_rcnt = rcnt_ff - 32'h0000_0001;
    if (rx_in.valid && rx_ready)
    begin
      nxt_bcc = bcc_ff ^ rx_in.data;
      case (pst_ff)
        P_STX:
        begin
          // Anything but a start character is dropped
          nxt_bcc = rx_in.data;
          if (rx_in.data == `CH_STX)
            nxt_pst = P_CLS;
        end
        P_CLS:
        begin
          nxt_cls = rx_in.data;
          nxt_pst = P_FN;
        end
        P_FN:
        begin
          nxt_fn = rx_in.data;
          nxt_pst = P_LEN;
        end
        P_LEN:
        begin
          nxt_clen = rx_in.data;
          nxt_cnt = 8'h00;
          nxt_pst = (rx_in.data == 8'h00) ? P_ETX : P_DAT;
        end
        P_DAT:
        begin
          // Keep the first five bytes, count the rest
          if (cnt_ff < 8'h05)
            nxt_dat[cnt_ff[2:0]] = rx_in.data;
          if (cls_ff == `CLS_CAL)
            nxt_meas = rx_bit_period;
          nxt_cnt = cnt_ff + 8'h01;
          if (cnt_ff + 8'h01 == clen_ff)
            nxt_pst = P_ETX;
        end
        P_ETX:
        begin
          nxt_etxok = (rx_in.data == `CH_ETX);
          nxt_pst = P_BCC;
        end
        P_BCC:
        begin
          nxt_pst = P_STX;
          go_rsp = 1'b1;
          // Reception errors first, in fixed priority
          if (!etxok_ff)
            err = `ERR_STXETX;
          else if (rx_in.data != bcc_ff)
            err = `ERR_BCC;
          else if (!known_cmd(cls_ff, fn_ff))
            err = `ERR_UNKNOWN;
          else if (clen_ff != exp_len(cls_ff))
            err = `ERR_LEN;
          else
          begin
            case (cls_ff)
              `CLS_VER:
              begin
                rsp_n = `LEN_VER_RSP;
                for (int i = 0; i < 16; i++) rsp_d[i] = VER_TEXT[127 - 8 * i -: 8];
              end
              `CLS_PARAM:
              begin
                nxt_mode = dat_ff[0];
                nxt_ate = dat_ff[2];
                rsp_n = `LEN_PARAM;
                rsp_d[0] = dat_ff[0];
                rsp_d[2] = dat_ff[2];
              end
              `CLS_CAL:
              begin
                nxt_baud = per;
                nxt_cal = per[12:5];
                nxt_cald = 1'b1;
                rsp_n = `LEN_ONE;
                rsp_d[0] = per[12:5];
              end
              `CLS_OTP:
              begin
                if (otpn_ff == `OTP_MAX)
                  err = `ERR_OTP_FULL;
                else if (!cald_ff)
                  err = `ERR_OTP_EMPTY;
                else
                begin
                  nxt_otpv = cal_ff;
                  nxt_otpn = otpn_ff + 3'h1;
                  nxt_otpw = 1'b1;
                  rsp_n = `LEN_ONE;
                  rsp_d[0] = cal_ff;
                end
              end
              `CLS_STAT:
              begin
                rsp_n = `LEN_STAT_RSP;
                rsp_d[0] = mode_ff;
                rsp_d[2] = ate_ff;
                rsp_d[5] = cal_ff;
              end
              `CLS_RETRY:
              begin
                if (have_ff)
                begin
                  go_rsp = 1'b0;
                  go_frm = 1'b1;
                end
                else
                  err = `ERR_NODATA;
              end
              default:
              begin
                // Software reset: silent, defaults and OTP reload
                go_rsp = 1'b0;
                rst_go = 1'b1;
                nxt_rcnt = SWRST_LOAD;
                nxt_mode = `RST_TX_MODE;
                nxt_ate = `RST_ALL_ERR;
                nxt_have = 1'b0;
                nxt_cald = (otpn_ff != 3'h0);
                nxt_cal = (otpn_ff != 3'h0) ? otpv_ff : 8'h00;
                nxt_baud = 16'h0000;
              end
            endcase
          end
          if (err != 8'h00)
          begin
            rsp_ack = 1'b0;
            rsp_n = `LEN_ONE;
            rsp_d[0] = err;
          end
        end
        default: nxt_pst = P_STX;
      endcase
    end
    // Card result from the decoder is kept for a later retry
    if (card_take)
    begin
      nxt_last = card_in.trk;
      nxt_lmode = `MODE_BASE + mode_ff;
      nxt_have = 1'b1;
      go_frm = 1'b1;
    end
  end

  // Parser and settings registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pst_ff <= P_STX; cls_ff <= 8'h00; fn_ff <= 8'h00; clen_ff <= 8'h00; cnt_ff <= 8'h00;
      for (int i = 0; i < 5; i++) dat_ff[i] <= 8'h00;
      bcc_ff <= 8'h00; etxok_ff <= 1'b0; meas_ff <= 16'h0000;
      mode_ff <= `RST_TX_MODE; ate_ff <= `RST_ALL_ERR; cal_ff <= 8'h00; cald_ff <= 1'b0;
      baud_ff <= 16'h0000; otpn_ff <= 3'h0; otpv_ff <= 8'h00; otpw_ff <= 1'b0;
      rcnt_ff <= 32'h0000_0000; have_ff <= 1'b0; last_ff <= '0; lmode_ff <= 8'h00;
    end
    else
    begin
      pst_ff <= nxt_pst; cls_ff <= nxt_cls; fn_ff <= nxt_fn; clen_ff <= nxt_clen; cnt_ff <= nxt_cnt;
      dat_ff <= nxt_dat; bcc_ff <= nxt_bcc; etxok_ff <= nxt_etxok; meas_ff <= nxt_meas;
      mode_ff <= nxt_mode; ate_ff <= nxt_ate; cal_ff <= nxt_cal; cald_ff <= nxt_cald;
      baud_ff <= nxt_baud; otpn_ff <= nxt_otpn; otpv_ff <= nxt_otpv; otpw_ff <= nxt_otpw;
      rcnt_ff <= nxt_rcnt; have_ff <= nxt_have; last_ff <= nxt_last; lmode_ff <= nxt_lmode;
    end
  end

  // Frame builder and byte transmitter
  always_comb
  begin
    int p;
    int ln;
    track_t tk;
    p = 2; ln = 0; tk = '0;
    nxt_tst = tst_ff; nxt_buf = buf_ff; nxt_n = n_ff; nxt_idx = idx_ff;
    nxt_tbcc = tbcc_ff; nxt_out = out_ff;
    if (tst_ff == T_IDLE && (go_rsp || go_frm))
    begin
      nxt_buf[0] = `CH_STX;
      if (go_rsp)
      begin
        nxt_buf[1] = cls_ff;
        nxt_buf[2] = fn_ff;
        nxt_buf[3] = rsp_n;
        nxt_buf[4] = rsp_ack ? `CH_ACK : `CH_NAK;
        for (int i = 0; i < 16; i++) nxt_buf[5 + i] = rsp_d[i];
        nxt_buf[5 + int'(rsp_n)] = `CH_ETX;
        nxt_n = 6'(6 + int'(rsp_n));
      end
      else
      begin
        // Raw binary bytes per track, in stored order
        nxt_buf[1] = card_take ? `MODE_BASE + mode_ff : lmode_ff;
        for (int t = 0; t < 3; t++)
        begin
          tk = card_take ? card_in.trk[t] : last_ff[t];
          ln = (int'(tk.len) > TRK_MAX) ? TRK_MAX : int'(tk.len);
          nxt_buf[p] = trk_id(t);
          if (tk.ok)
          begin
            nxt_buf[p + 1] = 8'(ln);
            nxt_buf[p + 2] = `CH_ACK;
            for (int k = 0; k < TRK_MAX; k++)
              if (k < ln) nxt_buf[p + 3 + k] = tk.data[k * 8 +: 8];
            p = p + 3 + ln;
          end
          else
          begin
            nxt_buf[p + 1] = `LEN_ONE;
            nxt_buf[p + 2] = `CH_NAK;
            nxt_buf[p + 3] = tk.code;
            p = p + 4;
          end
        end
        nxt_buf[p] = `CH_ETX;
        nxt_n = 6'(p + 1);
      end
      nxt_out = '{valid: 1'b1, data: `CH_STX};
      nxt_tbcc = `CH_STX;
      nxt_idx = 6'd1;
      nxt_tst = T_SEND;
    end
    else if (tst_ff == T_SEND && tx_ready)
    begin
      // Advance one byte per accepted byte; check byte last
      if (idx_ff < n_ff)
      begin
        nxt_out = '{valid: 1'b1, data: buf_ff[idx_ff]};
        nxt_tbcc = tbcc_ff ^ buf_ff[idx_ff];
        nxt_idx = idx_ff + 6'd1;
      end
      else if (idx_ff == n_ff)
      begin
        nxt_out = '{valid: 1'b1, data: tbcc_ff};
        nxt_idx = idx_ff + 6'd1;
      end
      else
      begin
        nxt_out = '{valid: 1'b0, data: 8'h00};
        nxt_tst = T_IDLE;
      end
    end
  end

  // Transmitter registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tst_ff <= T_IDLE;
      for (int i = 0; i < BUF_N; i++) buf_ff[i] <= 8'h00;
      n_ff <= 6'd0; idx_ff <= 6'd0; tbcc_ff <= 8'h00; out_ff <= '0;
    end
    else
    begin
      tst_ff <= nxt_tst; buf_ff <= nxt_buf; n_ff <= nxt_n; idx_ff <= nxt_idx;
      tbcc_ff <= nxt_tbcc; out_ff <= nxt_out;
    end
  end

  a_ver_len: assert property (@(posedge sys_clk) disable iff (rst)
    go_rsp && rsp_ack && cls_ff == `CLS_VER |=> buf_ff[3] == 8'h10 && buf_ff[21] == `CH_ETX)
    else $error("version answer length wrong");
  a_param_echo: assert property (@(posedge sys_clk) disable iff (rst)
    go_rsp && rsp_ack && cls_ff == `CLS_PARAM |=> mode_ff == buf_ff[5] && ate_ff == buf_ff[7])
    else $error("parameter echo differs from stored");
  a_otp_limit: assert property (@(posedge sys_clk) disable iff (rst)
    otpn_ff == 3'h4 && exec |=> !otpw_ff)
    else $error("OTP written past its limit");
  a_swrst_silent: assert property (@(posedge sys_clk) disable iff (rst)
    rst_go |=> (tst_ff == T_IDLE && busy)[*8])
    else $error("software reset answered or not busy");
  a_retry_code: assert property (@(posedge sys_clk) disable iff (rst)
    exec && cls_ff == `CLS_RETRY && !have_ff |-> !go_frm && go_rsp && !rsp_ack)
    else $error("retry without frame not refused");
  a_mode_byte: assert property (@(posedge sys_clk) disable iff (rst)
    tst_ff == T_IDLE && card_take |=> buf_ff[1] == $past(mode_ff) + 8'h31)
    else $error("frame mode byte wrong");
  a_nak_form: assert property (@(posedge sys_clk) disable iff (rst)
    go_rsp && !rsp_ack |=> buf_ff[3] == 8'h01 && buf_ff[4] == 8'h15 && buf_ff[6] == 8'h03)
    else $error("NAK response malformed");
  a_echo_cls: assert property (@(posedge sys_clk) disable iff (rst)
    go_rsp |=> buf_ff[1] == $past(cls_ff) && buf_ff[2] == $past(fn_ff))
    else $error("class or function not echoed");
  a_stx_first: assert property (@(posedge sys_clk) disable iff (rst)
    tst_ff == T_IDLE && (go_rsp || go_frm) |=> tx_out.valid && tx_out.data == 8'h02)
    else $error("response does not open with start");
endmodule

// file: testbench/host_model.sv
// Host side model: sends framed commands and drains response bytes
`timescale 1ns/10ps
module host_model
(
  input wire logic sys_clk,
  input wire logic rx_ready,
  input wire card_reader_pkg::byte_t tx_out,
  input wire logic slow,
  output card_reader_pkg::byte_t rx_in,
  output logic tx_ready
);
  import card_reader_pkg::*;
  logic [7:0] rsp_q[$]; // Bytes taken from the device
  logic [1:0] pace_ff; // Drain pacing count
  initial
  begin
    rx_in = '0;
    tx_ready = 1'b0;
    pace_ff = '0;
  end
  // Take bytes every edge, or one edge in four when slow
  always @(posedge sys_clk)
  begin
    pace_ff <= pace_ff + 2'h1;
    tx_ready <= !slow || (pace_ff == 2'h3);
    if (tx_out.valid === 1'b1 && tx_ready === 1'b1)
      rsp_q.push_back(tx_out.data);
  end
  // Frame and send one command, bytes back to back
  task automatic send(input logic [7:0] cls, fn, input logic [7:0] d[$], input logic [7:0] etx, flip);
    logic [7:0] f[$];
    logic [7:0] x;
    f = {8'h02, cls, fn, 8'(d.size())};
    f = {f, d, etx};
    x = '0;
    foreach (f[i]) x ^= f[i];
    f.push_back(x ^ flip);
    @(posedge sys_clk);
    foreach (f[i])
    begin
      rx_in <= {1'b1, f[i]};
      @(posedge sys_clk);
    end
    rx_in <= '0;
  endtask
endmodule

// file: testbench/test_card_reader_command_interpreter.sv
// Self-checking bench of the card reader command interpreter
`timescale 1ns/10ps
module test_card_reader_command_interpreter;
  import card_reader_pkg::*;
  typedef logic [7:0] bq_t[$];
  // Arbitrary version text
  localparam logic [127:0] VER = 128'h5445_5354_2054_4558_5420_563A_302E_3031;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic slow = 1'b0; // Host drain pacing
  byte_t rx_in, tx_out;
  logic rx_ready, tx_ready, card_ready, otp_wr, busy;
  logic [15:0] rx_bit_period = '0;
  logic [15:0] baud_period;
  logic [7:0] otp_wdata;
  card_t card_in = '0;
  bq_t nil; // Empty data field
  int fail_count = 0;
  int samples_checked = 0;
  int otp_pulses = 0; // OTP write strobes seen
  always #12.5 sys_clk = !sys_clk;
  // Count OTP write strobes
  always @(posedge sys_clk)
    if (otp_wr === 1'b1)
      otp_pulses++;
  card_reader_cmd #(.SWRST_CYCLES(20), .VER_TEXT(VER)) dut (.sys_clk(sys_clk), .rst(rst), .rx_in(rx_in),
    .rx_ready(rx_ready), .rx_bit_period(rx_bit_period), .tx_out(tx_out), .tx_ready(tx_ready),
    .card_in(card_in), .card_ready(card_ready), .baud_period(baud_period), .otp_wr(otp_wr),
    .otp_wdata(otp_wdata), .busy(busy));
  host_model host (.sys_clk(sys_clk), .rx_ready(rx_ready), .tx_out(tx_out), .slow(slow), .rx_in(rx_in),
    .tx_ready(tx_ready));
  // Byte compare
  task automatic check8(input logic [7:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask
  // Word or count compare
  task automatic check16(input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask
  // Append XOR check byte
  function automatic bq_t frame(input bq_t b);
    logic [7:0] x;
    x = '0;
    foreach (b[i]) x ^= b[i];
    b.push_back(x);
    return b;
  endfunction
  // Expected response frame
  function automatic bq_t rsp(input logic [7:0] c, f, s, input bq_t d);
    bq_t b;
    b = {8'h02, c, f, 8'(d.size()), s};
    b = {b, d, 8'h03};
    return frame(b);
  endfunction
  // Wait for a whole response, then compare it byte by byte
  task automatic expect_rsp(input bq_t e);
    int n;
    n = 0;
    while (host.rsp_q.size() < e.size() && n < 600)
    begin
      @(posedge sys_clk);
      n++;
    end
    repeat (8) @(posedge sys_clk);
    check16(16'(host.rsp_q.size()), 16'(e.size()));
    foreach (e[i]) if (i < host.rsp_q.size()) check8(host.rsp_q[i], e[i]);
    host.rsp_q.delete();
  endtask
  task automatic cmd(input logic [7:0] c, f, input bq_t d);
    host.send(c, f, d, 8'h03, 8'h00);
  endtask
  // Defaults after reset, OTP write before calibration
  task automatic t_defaults();
    cmd(8'h16, 8'h31, nil);
    expect_rsp(rsp(8'h16, 8'h31, 8'h06, '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}));
    cmd(8'h15, 8'h33, nil);
    expect_rsp(rsp(8'h15, 8'h33, 8'h15, '{8'h72}));
  endtask
  // Version text, most significant character first
  task automatic t_version();
    bq_t d;
    for (int i = 0; i < 16; i++) d.push_back(VER[127 - 8 * i -: 8]);
    cmd(8'h10, 8'h31, nil);
    expect_rsp(rsp(8'h10, 8'h31, 8'h06, d));
  endtask
  // Parameter load under a stalling host, then status
  task automatic t_param();
    slow <= 1'b1;
    cmd(8'h12, 8'h31, '{8'h02, 8'h00, 8'h01, 8'h00});
    expect_rsp(rsp(8'h12, 8'h31, 8'h06, '{8'h02, 8'h00, 8'h01, 8'h00}));
    cmd(8'h16, 8'h31, nil);
    expect_rsp(rsp(8'h16, 8'h31, 8'h06, '{8'h02, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00}));
    slow <= 1'b0;
  endtask
  // Calibration above the slow limit, then in range
  task automatic t_cal();
    logic [15:0] p[2] = '{16'h1388, 16'h0BB8};
    logic [15:0] b[2] = '{16'h1046, 16'h0BB8};
    logic [7:0] v[2] = '{8'h82, 8'h5D};
    for (int i = 0; i < 2; i++)
    begin
      rx_bit_period <= p[i];
      cmd(8'h13, 8'h31, '{8'hAA, 8'hAA, 8'hAA, 8'hAA, 8'hAA});
      expect_rsp(rsp(8'h13, 8'h31, 8'h06, '{v[i]}));
      check16(baud_period, b[i]);
    end
  endtask
  // Four OTP writes succeed, the fifth is refused
  task automatic t_otp();
    for (int i = 0; i < 4; i++)
    begin
      cmd(8'h15, 8'h33, nil);
      expect_rsp(rsp(8'h15, 8'h33, 8'h06, '{8'h5D}));
    end
    cmd(8'h15, 8'h33, nil);
    expect_rsp(rsp(8'h15, 8'h33, 8'h15, '{8'h71}));
    check16(16'(otp_pulses), 16'h0004);
    check8(otp_wdata, 8'h5D);
  endtask
  // Reception faults: class, function, data count, end, flip, code
  task automatic t_errors();
    logic [7:0] t[5][6];
    bq_t d;
    t = '{'{8'h10, 8'h31, 0, 8'h04, 0, 8'h61}, '{8'h18, 8'h31, 0, 8'h03, 8'hFF, 8'h63},
      '{8'h11, 8'h31, 0, 8'h03, 0, 8'h62}, '{8'h10, 8'h31, 1, 8'h03, 0, 8'h64},
      '{8'h17, 8'h31, 0, 8'h03, 0, 8'h65}};
    for (int i = 0; i < 5; i++)
    begin
      d = nil;
      if (t[i][2] != 0)
        d = '{8'h00};
      host.send(t[i][0], t[i][1], d, t[i][3], t[i][4]);
      expect_rsp(rsp(t[i][0], t[i][1], 8'h15, '{t[i][5]}));
    end
  endtask
  // Card data frame with one good and two failed tracks, then retry
  task automatic t_card();
    card_t c;
    bq_t e;
    c = '0;
    c.valid = 1'b1;
    c.trk[0].ok = 1'b1;
    c.trk[0].len = 8'h03;
    c.trk[0].data = 64'h0000_0000_00CC_BBAA;
    c.trk[1].code = 8'h53;
    c.trk[2].code = 8'h55;
    slow <= 1'b1;
    @(posedge sys_clk);
    card_in <= c;
    @(posedge sys_clk);
    card_in <= '0;
    e = '{8'h02, 8'h33, 8'h25, 8'h03, 8'h06, 8'hAA, 8'hBB, 8'hCC, 8'h3F, 8'h01, 8'h15, 8'h53,
      8'h5E, 8'h01, 8'h15, 8'h55, 8'h03};
    e = frame(e);
    expect_rsp(e);
    cmd(8'h17, 8'h31, nil);
    expect_rsp(e);
    slow <= 1'b0;
  endtask
  // Software reset: silent, busy span, defaults and OTP value back
  task automatic t_swrst();
    int n;
    cmd(8'h18, 8'h31, nil);
    n = 0;
    for (int k = 0; k < 100; k++)
    begin
      #1;
      if (busy === 1'b1 && rx_ready === 1'b0 && card_ready === 1'b0)
        n++;
      @(posedge sys_clk);
    end
    check16(16'(n), 16'h0014);
    check8({5'h00, rx_ready, card_ready, busy}, 8'h06);
    check16(16'(host.rsp_q.size()), 16'h0000);
    check16(baud_period, 16'h0000);
    cmd(8'h16, 8'h31, nil);
    expect_rsp(rsp(8'h16, 8'h31, 8'h06, '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h5D}));
    cmd(8'h17, 8'h31, nil);
    expect_rsp(rsp(8'h17, 8'h31, 8'h15, '{8'h65}));
  endtask
  // Counts and verdict, then stop
  task automatic conclude();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_defaults();
    t_version();
    t_param();
    t_cal();
    t_otp();
    t_errors();
    t_card();
    t_swrst();
    conclude();
  end
  // Watchdog well beyond the expected run
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    $display("unexpected at %0t: run did not finish", $time);
    conclude();
  end
endmodule
